//--- rtl/hlt_limit.sv
`timescale 1ns/1ns
module hlt_limit #(
	parameter int TICK_CYCLES = hlt_pkg::SEC_CYC // Shorten for simulation
) (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic [15:0] meas_i, // Absolute humidity, 0.01 g/m3
	input wire logic meas_valid_i, // New measurement pulse
	input wire logic meas_fmt_i, // 0: unsigned g/m3, 1: 2-byte float
	input wire logic [1:0] ext_mode_i, // Limit source
	input wire logic [3:0] thr_sel_i, // Configured threshold choice
	input wire logic [2:0] hyst_sel_i, // Hysteresis choice
	input wire logic [3:0] act_sel_i, // Activation choice 0..11
	input wire logic [3:0] on_dly_i, // Switch-on delay choice
	input wire logic [3:0] off_dly_i, // Switch-off delay choice
	input wire logic send_chg_i, // Send on change
	input wire logic [6:0] cyc_i, // Cyclic period, x10 s
	input wire logic cfg_load_i, // Configuration download pulse
	input wire logic ext_wr_i, // External limit write pulse
	input wire logic [15:0] ext_val_i, // External limit value
	input wire logic store_i, // Teach store pulse
	output logic [15:0] meas_obj_o, // Encoded measured value
	output logic meas_tx_o, // Measured value send pulse
	output logic [15:0] limit_o, // Active limit, 0.01 g/m3
	output logic lim_state_o, // Accepted limit state
	output logic lim_tx_o, // Limit object send pulse
	output logic lim_val_o, // Value carried by that send
	output logic [6:0] lim_obj_o // Object number of that send
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [31:0] div; // Second prescaler
		logic tick; // One-second pulse
		logic [15:0] limit; // Active limit
		logic raw; // Undelayed target state
		logic prev; // Last seen accepted state
		logic [10:0] cyc_cnt; // Seconds into cycle
		logic [15:0] mobj; // Encoded measurement
		logic mtx; // Measurement send
		logic ltx; // Limit send
		logic lval; // Limit send value
	} hlt_lim_s;

	hlt_lim_s q, d;
	hlt_dly_if dly ();

	logic [16:0] hi_thr; // Limit plus hysteresis
	logic [15:0] lo_thr; // Limit minus hysteresis, clamped
	logic [15:0] hyst;
	logic exc_fam, val_a, nt_a, nt_b, cond_a, cond_b;
	logic [31:0] ext_dec; // Decoded 2-byte float
	logic [31:0] pct_dec; // Decoded percentage
	logic [10:0] cyc_len; // Cycle length in seconds
	logic [15:0] mant;
	logic [3:0] expo;

	// ----------------------------------------
	// Combinational next state
	// ----------------------------------------
	always_comb begin
		d = q;
		// Second tick from the reference clock
		d.tick = 1'b0;
		if (q.div >= 32'(TICK_CYCLES - 1)) begin
			d.div = 32'h0000_0000;
			d.tick = 1'b1;
		end else begin
			d.div = q.div + 32'h0000_0001;
		end

		// External value decoding
		ext_dec = {21'h000000, ext_val_i[10:0]} << ext_val_i[14:11];
		pct_dec = ({24'h000000, ext_val_i[7:0]} * {16'h0000, hlt_pkg::RANGE_TOP})
			/ {16'h0000, hlt_pkg::PCT_FULL};

		// Limit source; download wins over any external write
		if (cfg_load_i) begin
			d.limit = hlt_pkg::hlt_thr(thr_sel_i);
		end else if (store_i && ext_mode_i == hlt_pkg::HLT_EXT_TEACH) begin
			d.limit = meas_i;
		end else if (ext_wr_i && ext_mode_i == hlt_pkg::HLT_EXT_2B) begin
			// Negative floats give zero, oversize saturates
			if (ext_val_i[15]) begin
				d.limit = 16'h0000;
			end else if (ext_dec > 32'h0000_ffff) begin
				d.limit = 16'hffff;
			end else begin
				d.limit = ext_dec[15:0];
			end
		end else if (ext_wr_i && ext_mode_i == hlt_pkg::HLT_EXT_1B) begin
			d.limit = pct_dec[15:0];
		end

		// Activation decode: family, first value, no-telegram sides
		// Bit 1 low picks the exceed family in every group of four
		exc_fam = !act_sel_i[1];
		val_a = (act_sel_i < 4'h8) ? !act_sel_i[0] : act_sel_i[0];
		nt_a = (act_sel_i >= 4'h8) && (act_sel_i <= 4'hb);
		nt_b = (act_sel_i >= 4'h4) && (act_sel_i <= 4'h7);

		// Thresholds with hysteresis
		hyst = hlt_pkg::hlt_hyst(hyst_sel_i);
		hi_thr = {1'b0, q.limit} + {1'b0, hyst};
		lo_thr = (q.limit > hyst) ? q.limit - hyst : 16'h0000;
		cond_a = exc_fam ? (meas_i > q.limit) : (meas_i < q.limit);
		cond_b = exc_fam ? (meas_i < lo_thr) : ({1'b0, meas_i} > hi_thr);

		// A no-telegram crossing leaves the target alone
		if (cond_a && !nt_a) begin
			d.raw = val_a;
		end else if (cond_b && !nt_b) begin
			d.raw = nt_a ? val_a : !val_a;
		end

		// Change send, then cyclic send
		d.prev = dly.state;
		d.ltx = 1'b0;
		d.lval = dly.state;
		cyc_len = 11'(cyc_i) * 11'(hlt_pkg::CYC_UNIT_S);
		if (dly.state != q.prev && send_chg_i) begin
			d.ltx = 1'b1;
		end
		if (cyc_i == 7'h00) begin
			d.cyc_cnt = 11'h000;
		end else if (q.tick) begin
			if (q.cyc_cnt + 11'h001 >= cyc_len) begin
				d.cyc_cnt = 11'h000;
				// Held no-telegram condition mutes the repeat
				if (!((cond_a && nt_a) || (cond_b && nt_b))) begin
					d.ltx = 1'b1;
				end
			end else begin
				d.cyc_cnt = q.cyc_cnt + 11'h001;
			end
		end

		// Measured value object encoding
		mant = meas_i;
		expo = 4'h0;
		for (int i = 0; i < 6; i++) begin
			if (mant > {5'h00, hlt_pkg::MANT_MAX}) begin
				mant = mant >> 1;
				expo = expo + 4'h1;
			end
		end
		d.mtx = meas_valid_i;
		if (meas_valid_i) begin
			d.mobj = meas_fmt_i ? {1'b0, expo, mant[10:0]} : meas_i / 16'h0064;
		end
	end

	// Register the state
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			q <= '0;
			q.limit <= hlt_pkg::LIMIT_RST;
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------
	// Delay filter
	// ----------------------------------------
	assign dly.raw = q.raw;
	assign dly.tick = q.tick;
	assign dly.on_sel = on_dly_i;
	assign dly.off_sel = off_dly_i;

	hlt_delay u_delay (
		.ref_clk_i(ref_clk_i),
		.resetn_i(resetn_i),
		.dly(dly)
	);

	// Outputs straight from flip-flops, except the fixed object number
	assign meas_obj_o = q.mobj;
	assign meas_tx_o = q.mtx;
	assign limit_o = q.limit;
	assign lim_state_o = q.prev;
	assign lim_tx_o = q.ltx;
	assign lim_val_o = q.lval;
	assign lim_obj_o = hlt_pkg::OBJ_LIM2;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_change_sends: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		(dly.state != q.prev && send_chg_i) |=> lim_tx_o && lim_val_o == $past(dly.state))
		else $error("change not sent");
	a_never_sends: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		(!send_chg_i && cyc_i == 7'h00)[*2] |-> !lim_tx_o) else $error("silent mode sent");
	a_teach_copy: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		(store_i && !cfg_load_i && ext_mode_i == hlt_pkg::HLT_EXT_TEACH)
		|=> limit_o == $past(meas_i)) else $error("teach not stored");
	a_download_cfg: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		cfg_load_i |=> limit_o == hlt_pkg::hlt_thr($past(thr_sel_i))) else $error("download lost");
	a_ext_ignored: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		(ext_wr_i && !store_i && !cfg_load_i && ext_mode_i == hlt_pkg::HLT_EXT_NONE)
		|=> $stable(limit_o)) else $error("external used while off");
	a_tx_value: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		lim_tx_o |-> lim_val_o == $past(dly.state)) else $error("wrong value sent");
	// Measured object leaves one cycle after each new sample
	a_meas_send: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		meas_valid_i |=> meas_tx_o) else $error("measured value not sent");
	a_meas_hold: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		!meas_valid_i |=> !meas_tx_o && $stable(meas_obj_o))
		else $error("measured value moved");
	// Negative external floats clamp the limit to zero
	a_ext_negative: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		(ext_wr_i && !cfg_load_i && ext_mode_i == hlt_pkg::HLT_EXT_2B && ext_val_i[15])
		|=> limit_o == 16'h0000) else $error("negative limit not clamped");
	// Full-scale percent gives the range top
	a_pct_top: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		(ext_wr_i && !cfg_load_i && ext_mode_i == hlt_pkg::HLT_EXT_1B
		&& ext_val_i[7:0] == 8'hff) |=> limit_o == hlt_pkg::RANGE_TOP)
		else $error("percent top wrong");
	// Without change sends only a tick can launch a telegram
	a_no_chg_send: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		(!send_chg_i && !q.tick) |=> !lim_tx_o) else $error("change sent while off");
	// A held no-telegram condition mutes the repeat as well
	a_cyc_muted: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		(!send_chg_i && ((cond_a && nt_a) || (cond_b && nt_b))) |=> !lim_tx_o)
		else $error("cyclic send not muted");
endmodule

//--- rtl/hlt_pkg.sv
// Contract
// - Limit from config, 2-byte, 1-byte or teach
// - Teach copies present measurement into limit
// - Download restores configured limit, drops external
// - Switch-on accepted only after switch-on delay
// - Cyclic sends old 0 during on-delay
// - Switch-off delay likewise; cyclic keeps 1
// - No-telegram condition also suppresses cyclic sends
// - Send-on-change sends every 0/1 transition
// - Cyclic setting nonzero sends periodically unless a no-telegram condition holds
// - Cyclic period is setting times ten seconds
// - No change-send and zero cycle: silent
// - Measured object as 7.001 or 9.029
// - Limit objects are 1-bit switch values
// - External limit accepted as 2-byte float
// - External limit accepted as 1-byte percent
// - Activation picks direction, value, no-telegram cases
// - Threshold 10..80 g/m3, hysteresis up to 10
package hlt_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 40; // 25 MHz reference
	localparam int SEC_NS = 1000000000; // One second in ns
	localparam int SEC_CYC = SEC_NS / CLK_PERIOD_NS; // Cycles per second tick
	localparam int CYC_UNIT_S = 10; // Cyclic step in seconds

	// ----------------------------------------
	// Object numbers and values
	// ----------------------------------------
	localparam logic [6:0] OBJ_MEAS = 7'h1a; // Measured value object 26
	localparam logic [6:0] OBJ_LIM1 = 7'h2c; // Limit 1 state object 44
	localparam logic [6:0] OBJ_LIM2 = 7'h3c; // Limit 2 state object 60
	localparam logic [6:0] OBJ_EXT2 = 7'h5c; // External limit 2 object 92
	localparam logic [15:0] RANGE_TOP = 16'h1f40; // Range top, 0.01 g/m3 units
	localparam logic [15:0] LIMIT_RST = 16'h0fa0; // 40 g/m3 before first download
	localparam logic [10:0] MANT_MAX = 11'h7ff; // Largest float mantissa
	localparam logic [15:0] PCT_FULL = 16'h00ff; // 1-byte full scale

	// Source of the limit
	typedef enum logic [1:0] {
		HLT_EXT_NONE = 2'b00,
		HLT_EXT_2B = 2'b01,
		HLT_EXT_1B = 2'b10,
		HLT_EXT_TEACH = 2'b11
	} hlt_ext_e;

	// Threshold table in 0.01 g/m3
	function automatic logic [15:0] hlt_thr(input logic [3:0] s);
		case (s)
			4'h0: hlt_thr = 16'h03e8;
			4'h1: hlt_thr = 16'h05dc;
			4'h2: hlt_thr = 16'h07d0;
			4'h3: hlt_thr = 16'h09c4;
			4'h4: hlt_thr = 16'h0bb8;
			4'h5: hlt_thr = 16'h0dac;
			4'h6: hlt_thr = 16'h0fa0;
			4'h7: hlt_thr = 16'h1388;
			4'h8: hlt_thr = 16'h1770;
			4'h9: hlt_thr = 16'h1b58;
			default: hlt_thr = 16'h1f40;
		endcase
	endfunction

	// Hysteresis table in 0.01 g/m3
	function automatic logic [15:0] hlt_hyst(input logic [2:0] s);
		case (s)
			3'h0: hlt_hyst = 16'h0000;
			3'h1: hlt_hyst = 16'h00c8;
			3'h2: hlt_hyst = 16'h012c;
			3'h3: hlt_hyst = 16'h01f4;
			3'h4: hlt_hyst = 16'h02bc;
			default: hlt_hyst = 16'h03e8;
		endcase
	endfunction

	// Delay table in seconds
	function automatic logic [11:0] hlt_dly(input logic [3:0] s);
		case (s)
			4'h0: hlt_dly = 12'h000;
			4'h1: hlt_dly = 12'h001;
			4'h2: hlt_dly = 12'h003;
			4'h3: hlt_dly = 12'h005;
			4'h4: hlt_dly = 12'h00a;
			4'h5: hlt_dly = 12'h00f;
			4'h6: hlt_dly = 12'h01e;
			4'h7: hlt_dly = 12'h03c;
			4'h8: hlt_dly = 12'h0b4;
			4'h9: hlt_dly = 12'h12c;
			4'ha: hlt_dly = 12'h258;
			4'hb: hlt_dly = 12'h384;
			4'hc: hlt_dly = 12'h708;
			default: hlt_dly = 12'he10;
		endcase
	endfunction

endpackage

//--- rtl/hlt_dly_if.sv
`timescale 1ns/1ns
// Raw condition in, delayed accepted state out
interface hlt_dly_if;
	logic raw; // Undelayed target state
	logic tick; // One-second pulse
	logic [3:0] on_sel; // Switch-on delay choice
	logic [3:0] off_sel; // Switch-off delay choice
	logic state; // Accepted limit state
	logic busy; // Delay timer running
	modport ctrl (output raw, output tick, output on_sel, output off_sel,
		input state, input busy);
	modport filt (input raw, input tick, input on_sel, input off_sel,
		output state, output busy);
endinterface

//--- rtl/hlt_delay.sv
`timescale 1ns/1ns
module hlt_delay (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	hlt_dly_if.filt dly
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic st; // Accepted state
		logic busy; // Timer running
		logic [11:0] cnt; // Elapsed seconds
	} hlt_dly_s;

	hlt_dly_s q, d;
	logic [11:0] need; // Delay for pending direction

	// Accept raw state after its direction's delay
	always_comb begin
		d = q;
		need = dly.raw ? hlt_pkg::hlt_dly(dly.on_sel) : hlt_pkg::hlt_dly(dly.off_sel);
		if (dly.raw == q.st) begin
			// Condition reverted or settled: drop the timer
			d.busy = 1'b0;
			d.cnt = 12'h000;
		end else if (need == 12'h000) begin
			d.st = dly.raw;
		end else if (!q.busy) begin
			d.busy = 1'b1;
			d.cnt = 12'h000;
		end else if (dly.tick) begin
			// Old state stays until full delay has elapsed
			if (q.cnt + 12'h001 >= need) begin
				d.st = dly.raw;
				d.busy = 1'b0;
				d.cnt = 12'h000;
			end else begin
				d.cnt = q.cnt + 12'h001;
			end
		end
	end

	// Register the state
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign dly.state = q.st;
	assign dly.busy = q.busy;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_no_delay_follow: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		(dly.raw != dly.state && hlt_pkg::hlt_dly(dly.raw ? dly.on_sel : dly.off_sel) == 12'h000)
		|=> dly.state == $past(dly.raw)) else $error("zero delay not followed");
	a_revert_cancel: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		(dly.raw == dly.state) |=> !dly.busy) else $error("timer not cancelled");
	a_hold_old: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		(dly.busy && !dly.tick) |=> $stable(dly.state)) else $error("state moved early");
endmodule

//--- testbench/hlt_bus_peer.sv
`timescale 1ns/1ns
// ----------------------------------------
// Bus peer: value transmitter, teach button
// ----------------------------------------
module hlt_bus_peer (
	input wire logic ref_clk_i,
	input wire logic lim_tx_i,
	output logic ext_wr_o,
	output logic [15:0] ext_val_o,
	output logic store_o
);
	int rx_n = 0; // Limit telegrams heard
	initial begin
		ext_wr_o = 1'b0;
		ext_val_o = 16'h0000;
		store_o = 1'b0;
	end
	// Listener side of the bus
	always @(posedge ref_clk_i) if (lim_tx_i === 1'b1) rx_n <= rx_n + 1;
	// One value telegram; data scrambled once released so stale data is not read
	task automatic send_val(input logic [15:0] v);
		@(posedge ref_clk_i);
		ext_wr_o <= 1'b1;
		ext_val_o <= v;
		@(posedge ref_clk_i);
		ext_wr_o <= 1'b0;
		ext_val_o <= ~v;
	endtask
	// Teach press: one switching telegram
	task automatic press();
		@(posedge ref_clk_i);
		store_o <= 1'b1;
		@(posedge ref_clk_i);
		store_o <= 1'b0;
	endtask
endmodule

//--- testbench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
	// ----------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------
	logic ref_clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic [15:0] meas = 16'h0000;
	logic mvalid = 1'b0;
	logic fmt = 1'b0;
	logic [1:0] mode = 2'h0;
	logic [3:0] thr = 4'h0;
	logic [2:0] hyst = 3'h0; // Hysteresis choice, none at first
	logic [3:0] act = 4'h0;
	logic [3:0] on_d = 4'h0;
	logic [3:0] off_d = 4'h0;
	logic chg = 1'b0;
	logic [6:0] cyc = 7'h00;
	logic load = 1'b0;
	logic ext_wr, store, m_tx, st, l_tx, l_val;
	logic [15:0] ext_val, m_obj, lim;
	logic [6:0] l_obj;
	int bad_count = 0;
	int n_compared = 0;
	logic [23:0] exp_q[$]; // Expected telegrams, oldest first
	logic [15:0] rnd = 16'hf249; // Seed 62025
	logic [15:0] v;
	int n;
	logic [15:0] thr_tab [11] = '{16'h03e8, 16'h05dc, 16'h07d0, 16'h09c4, 16'h0bb8,
		16'h0dac, 16'h0fa0, 16'h1388, 16'h1770, 16'h1b58, 16'h1f40};

	always #20 ref_clk_i = ~ref_clk_i; // 25 MHz

	// Tick shortened to 20 cycles so a second is cheap
	hlt_limit #(.TICK_CYCLES(20)) dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
		.meas_i(meas), .meas_valid_i(mvalid), .meas_fmt_i(fmt), .ext_mode_i(mode),
		.thr_sel_i(thr), .hyst_sel_i(hyst), .act_sel_i(act), .on_dly_i(on_d),
		.off_dly_i(off_d), .send_chg_i(chg), .cyc_i(cyc), .cfg_load_i(load),
		.ext_wr_i(ext_wr), .ext_val_i(ext_val), .store_i(store), .meas_obj_o(m_obj),
		.meas_tx_o(m_tx), .limit_o(lim), .lim_state_o(st), .lim_tx_o(l_tx),
		.lim_val_o(l_val), .lim_obj_o(l_obj));
	hlt_bus_peer peer (.ref_clk_i(ref_clk_i), .lim_tx_i(l_tx), .ext_wr_o(ext_wr),
		.ext_val_o(ext_val), .store_o(store));

	// ----------------------------------------
	// Checking helpers
	// ----------------------------------------
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic timeout();
		bad_count++;
		$display("[ERR] %0t wait ran out", $time);
		end_of_test();
	endtask
	// Oldest note against each telegram; a telegram with no note is a fault
	task automatic take(input logic [23:0] seen);
		if (exp_q.size() == 0) begin
			check(seen, 24'hffffff);
		end else begin
			check(seen, exp_q.pop_front());
		end
	endtask
	always @(posedge ref_clk_i) begin
		if (m_tx === 1'b1) take({hlt_pkg::OBJ_MEAS, m_obj});
		if (l_tx === 1'b1) take({l_obj, 15'h0000, l_val});
	end
	// Step past the edge so its updates have landed
	task automatic step(input int k);
		repeat (k) @(posedge ref_clk_i);
		#1;
	endtask
	task automatic wait_st(input logic s, input int max);
		for (int i = 0; i < max && st !== s; i++) step(1);
		if (st !== s) timeout();
	endtask
	task automatic wait_q(input int max, output int k);
		for (k = 0; k < max && exp_q.size() != 0; k++) step(1);
		if (exp_q.size() != 0) timeout();
	endtask
	task automatic pulse_load();
		@(posedge ref_clk_i);
		load <= 1'b1;
		@(posedge ref_clk_i);
		load <= 1'b0;
	endtask
	task automatic pulse_meas();
		@(posedge ref_clk_i);
		mvalid <= 1'b1;
		@(posedge ref_clk_i);
		mvalid <= 1'b0;
	endtask
	task automatic chk_lim(input logic [15:0] e);
		step(2);
		check({8'h00, lim}, {8'h00, e});
	endtask
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		step(20);
		resetn_i <= 1'b1;
		chk_lim(16'h0fa0);
		// Value telegram ignored without external source
		peer.send_val(16'h0fa0);
		chk_lim(16'h0fa0);
		mode <= 2'h1;
		peer.send_val(16'h0fa0);
		chk_lim(16'h0f40);
		peer.send_val(16'h8123);
		chk_lim(16'h0000);
		mode <= 2'h2;
		peer.send_val(16'h00ff);
		chk_lim(16'h1f40);
		peer.send_val(16'h0033);
		chk_lim(16'h0640);
		meas <= 16'h1234;
		peer.press();
		chk_lim(16'h0640);
		mode <= 2'h3;
		peer.press();
		chk_lim(16'h1234);
		meas <= 16'h0000;
		// Downloads, ending at the lowest threshold
		for (int i = 10; i >= 0; i--) begin
			thr <= 4'(i);
			pulse_load();
			chk_lim(thr_tab[i]);
		end
		// Old external value not revived by the source switch
		mode <= 2'h1;
		chk_lim(16'h03e8);
		// Change sends without delay
		chg <= 1'b1;
		exp_q.push_back({hlt_pkg::OBJ_LIM2, 16'h0001});
		meas <= 16'h07d0;
		wait_st(1'b1, 10);
		wait_q(5, n);
		exp_q.push_back({hlt_pkg::OBJ_LIM2, 16'h0000});
		meas <= 16'h0000;
		wait_st(1'b0, 10);
		wait_q(5, n);
		// Three-second delays, first one aborted
		on_d <= 4'h2;
		off_d <= 4'h2;
		meas <= 16'h07d0;
		step(10);
		meas <= 16'h0000;
		step(80);
		check({23'h0, st}, 24'h0);
		meas <= 16'h07d0;
		step(30);
		check({23'h0, st}, 24'h0);
		exp_q.push_back({hlt_pkg::OBJ_LIM2, 16'h0001});
		wait_st(1'b1, 60);
		meas <= 16'h0000;
		step(30);
		check({23'h0, st}, 24'h1);
		exp_q.push_back({hlt_pkg::OBJ_LIM2, 16'h0000});
		wait_st(1'b0, 60);
		wait_q(5, n);
		// Cyclic send during a long on-delay still carries 0
		chg <= 1'b0;
		on_d <= 4'h6;
		exp_q.push_back({hlt_pkg::OBJ_LIM2, 16'h0000});
		cyc <= 7'h01;
		meas <= 16'h07d0;
		wait_q(220, n);
		cyc <= 7'h00;
		wait_st(1'b1, 700);
		// Cyclic period of ten seconds
		exp_q.push_back({hlt_pkg::OBJ_LIM2, 16'h0001});
		cyc <= 7'h01;
		wait_q(220, n);
		exp_q.push_back({hlt_pkg::OBJ_LIM2, 16'h0001});
		wait_q(220, n);
		check({23'h0, n >= 195 && n <= 205}, 24'h1);
		// Undershoot set to no telegram: state kept, cyclic muted
		act <= 4'h4;
		on_d <= 4'h0;
		off_d <= 4'h0;
		meas <= 16'h0000;
		step(450);
		check({23'h0, st}, 24'h1);
		// No change send and no cycle: silent both ways
		act <= 4'h0;
		cyc <= 7'h00;
		wait_st(1'b0, 10);
		meas <= 16'h07d0;
		wait_st(1'b1, 10);
		step(300);
		// Hysteresis in both families, 2 g/m3 around 10 g/m3
		hyst <= 3'h1;
		meas <= 16'h0384;
		step(10);
		check({23'h0, st}, 24'h1);
		meas <= 16'h02ee;
		wait_st(1'b0, 10);
		act <= 4'h2;
		wait_st(1'b1, 10);
		meas <= 16'h044c;
		step(10);
		check({23'h0, st}, 24'h1);
		meas <= 16'h0514;
		wait_st(1'b0, 10);
		act <= 4'h0;
		// Measured object, random values then float form
		for (int i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			v = rnd % 16'h1f40;
			meas <= v;
			exp_q.push_back({hlt_pkg::OBJ_MEAS, v / 16'h0064});
			pulse_meas();
			wait_q(5, n);
		end
		fmt <= 1'b1;
		meas <= 16'h0123;
		exp_q.push_back({hlt_pkg::OBJ_MEAS, 16'h0123});
		pulse_meas();
		wait_q(5, n);
		step(5);
		check(24'(exp_q.size()), 24'h0);
		check(24'(peer.rx_n), 24'h7);
		end_of_test();
	end
endmodule
